// ---- sim/touch_panel_model.sv ----
// converter and panel model answering the sequencer's conversion requests
`timescale 1ns/1ps
module touch_panel_model (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_i,
    // requests and panel state
    input wire logic conv_start_i,
    input wire logic [2:0] conv_chan_i,
    input wire logic press_i,
    input wire logic slow_i,
    // answers
    output logic conv_done_o,
    output logic [11:0] conv_data_o,
    output logic touch_o
);
    logic [3:0] cnt_ff;
    logic [11:0] val_ff;
    assign touch_o = press_i;
    // data bus shows the inverse of the last code outside the done cycle
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            cnt_ff <= 4'h0;
            val_ff <= 12'h000;
            conv_done_o <= 1'b0;
            conv_data_o <= 12'hFFF;
        end else begin
            conv_done_o <= 1'b0;
            conv_data_o <= ~val_ff;
            if (conv_start_i) begin
                cnt_ff <= slow_i ? 4'hC : 4'h2;
                val_ff <= 12'h010 + 12'h011 * {9'h000, conv_chan_i};
            end else if (cnt_ff != 4'h0) begin
                cnt_ff <= cnt_ff - 4'h1;
                if (cnt_ff == 4'h1) begin
                    conv_done_o <= 1'b1;
                    conv_data_o <= val_ff;
                end
            end
        end
    end
endmodule

// ---- sim/touch_seq_tb.sv ----
// self-checking bench for the touch and spare input sequencer
`timescale 1ns/1ps
module touch_seq_tb;
    typedef struct {
        logic [3:0] fn;
        logic [1:0] res;
        logic bm;
        logic [2:0] ch;
        logic [11:0] exp;
    } row_s;
    logic clk = 1'b0, rst = 1'b1, wr = 1'b0, bm = 1'b0, pd = 1'b0, tauto = 1'b0;
    logic rrd = 1'b0, frd = 1'b0, press = 1'b0, slow = 1'b0;
    logic [7:0] ctl = 8'h00, tmr = 8'h00;
    logic [1:0] res = 2'h0;
    logic start, done, touch, busy, osc, pwr, a1, a2, flag;
    logic scont = 1'b0, irq = 1'b1, apsel = 1'b0, tpsel = 1'b1;
    logic [2:0] chan;
    logic [2:0] stab = 3'h0;
    logic [11:0] data, xr, yr, ar, br, btr, t1r, t2r;
    int n_fail = 0, n_compared = 0, n_starts = 0, cyc = 0, w;
    row_s rows [9] = '{'{4'h9, 2'h2, 1'b0, 3'h2, 12'h00C}, '{4'h9, 2'h2, 1'b0, 3'h3, 12'h010},
        '{4'h9, 2'h2, 1'b0, 3'h4, 12'h069}, '{4'h4, 2'h1, 1'b0, 3'h2, 12'h003},
        '{4'h6, 2'h0, 1'b1, 3'h4, 12'h054}, '{4'h6, 2'h0, 1'b0, 3'h4, 12'h1A4},
        '{4'h6, 2'h1, 1'b0, 3'h4, 12'h019}, '{4'h7, 2'h0, 1'b0, 3'h5, 12'h065},
        '{4'h8, 2'h0, 1'b0, 3'h6, 12'h076}};

    touch_seq #(.PULSE_CYCLES(20), .MS_CYCLES(10)) i_touch_seq (
        .ref_clk_i(clk), .rst_i(rst), .conv_ctl_i(ctl), .ctl_wr_i(wr), .tmr_cfg_i(tmr),
        .stab_cfg_i(stab), .res_sel_i(res), .batt_mode_i(bm), .sar_pd_i(pd),
        .spare_cont_i(scont), .temp_auto_i(tauto), .temp_ivl_i(8'h03),
        .temp_min_i(12'h100), .temp_max_i(12'h200), .temp_irq_en_i(irq),
        .alert_pin_sel_i(apsel), .temp_pin_sel_i(tpsel), .res_rd_i(rrd), .flag_rd_i(frd),
        .touch_i(touch), .conv_done_i(done), .conv_data_i(data), .x_drv_o(), .y_drv_o(),
        .pchg_o(), .sense_o(), .sar_pwr_o(pwr), .osc_on_o(osc), .conv_start_o(start),
        .conv_chan_o(chan), .bias_hi_o(), .first_alert_pin_o(a1), .second_alert_pin_o(a2),
        .x_res_o(xr), .y_res_o(yr), .spare_input_a_res_o(ar), .spare_input_b_res_o(br),
        .batt_res_o(btr), .low_current_diode_reading_o(t1r),
        .high_current_diode_reading_o(t2r), .temp_flag_o(flag), .busy_o(busy));

    touch_panel_model i_touch_panel_model (.ref_clk_i(clk), .rst_i(rst), .conv_start_i(start),
        .conv_chan_i(chan), .press_i(press), .slow_i(slow), .conv_done_o(done),
        .conv_data_o(data), .touch_o(touch));

    always begin
        #50 clk = ~clk;
    end

    task automatic summarize();
        if (n_fail == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cyc++;
        if (start === 1'b1) n_starts++;
        if (cyc == 20000) begin
            n_fail++;
            summarize();
        end
    end

    task automatic chk_code(input logic [11:0] got, input logic [11:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic wait_idle();
        int i;
        tick(3);
        for (i = 0; i < 600 && busy !== 1'b0; i++)
            tick(1);
    endtask

    task automatic run_fn(input logic [3:0] fn);
        ctl = {2'b00, fn, 2'h1};
        wr = 1'b1;
        tick(1);
        wr = 1'b0;
        wait_idle();
    endtask

    function automatic logic [11:0] res_of(input logic [2:0] c);
        case (c)
            3'h2: return ar;
            3'h3: return br;
            3'h4: return btr;
            3'h5: return t1r;
            default: return t2r;
        endcase
    endfunction

    initial begin
        tick(3);
        rst = 1'b0;
        tick(1);
        foreach (rows[i]) begin
            res = rows[i].res;
            bm = rows[i].bm;
            slow = i[0];
            run_fn(rows[i].fn);
            chk_code(res_of(rows[i].ch), rows[i].exp);
            chk_bit(a1, 1'b0);
            rrd = 1'b1;
            tick(1);
            rrd = 1'b0;
            tick(1);
            chk_bit(a1, 1'b1);
        end
        // self mode: pen detect off first, then on
        res = 2'h0;
        ctl = 8'h84;
        press = 1'b1;
        tick(30);
        chk_bit(osc, 1'b0);
        stab = 3'h2;
        tmr = 8'h80;
        for (w = 0; w < 20 && a1 !== 1'b0; w++)
            tick(1);
        chk_bit(osc, 1'b1);
        chk_bit(a1, 1'b0);
        // stabilise code 2 waits 30 cycles, plus exit and start cycles
        for (w = 0; w < 40 && start !== 1'b1; w++)
            tick(1);
        chk_code(12'(w), 12'h020);
        for (w = 0; w < 800 && xr !== 12'h021; w++)
            tick(1);
        chk_code(yr, 12'h010);
        chk_code(xr, 12'h021);
        w = n_starts;
        tick(300);
        chk_bit(n_starts > w + 2, 1'b1);
        pd = 1'b1;
        tick(4);
        chk_bit(pwr, 1'b0);
        press = 1'b0;
        pd = 1'b0;
        wait_idle();
        chk_bit(a1, 1'b1);
        // spare input repeats, alert moved to the second pin
        apsel = 1'b1;
        scont = 1'b1;
        w = n_starts;
        run_fn(4'h5);
        chk_bit(n_starts > w + 3, 1'b1);
        scont = 1'b0;
        wait_idle();
        chk_bit(a2, 1'b0);
        chk_bit(a1, 1'b1);
        // automatic temperature with data alert left pending
        res = 2'h1;
        run_fn(4'h4);
        tauto = 1'b1;
        for (w = 0; w < 300 && a2 !== 1'b1; w++)
            tick(1);
        for (w = 0; w < 100 && a2 === 1'b1; w++)
            tick(1);
        chk_code(12'(w), 12'h014);
        chk_bit(flag, 1'b1);
        chk_code(t1r, 12'h006);
        tauto = 1'b0;
        tick(60);
        frd = 1'b1;
        tick(1);
        frd = 1'b0;
        tick(1);
        chk_bit(flag, 1'b0);
        // reset in mid-run clears results and pending alert
        rst = 1'b1;
        tick(1);
        rst = 1'b0;
        chk_bit(a2, 1'b1);
        chk_code(yr, 12'h000);
        chk_bit(osc, 1'b0);
        summarize();
    end
endmodule

// ---- src/code_scaler.sv ----
// trims a converter word to the resolution and optionally rescales by five
`timescale 1ns/1ps
module code_scaler (
    // inputs
    input wire logic [11:0] raw_i,
    input wire logic [1:0] res_i,
    input wire logic up5_i,
    // output
    output logic [11:0] code_o
);

    always_comb begin
        logic [11:0] c;
        logic [11:0] top;
        logic [14:0] p;
        c = raw_i;
        top = 12'hFFF;
        p = 15'h0000;
        unique case (res_i)
            touch_seq_pkg::RES_8: begin
                c = {4'h0, raw_i[11:4]};
                top = 12'h0FF;
            end
            touch_seq_pkg::RES_10: begin
                c = {2'h0, raw_i[11:2]};
                top = 12'h3FF;
            end
            default: begin
                c = raw_i;
                top = 12'hFFF;
            end
        endcase
        p = {3'h0, c} * 15'h0005;
        if (!up5_i) begin
            code_o = c;
        end else if (p > {3'h0, top}) begin
            code_o = top;
        end else begin
            code_o = p[11:0];
        end
    end

endmodule

// ---- src/input_sync.sv ----
// three-stage input synchroniser, output follows when stages two and three agree
`timescale 1ns/1ps
module input_sync (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_i,
    // data
    input wire logic d_i,
    output logic q_o
);

    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic q;
    } sync_s;

    sync_s q;
    sync_s n;

    always_comb begin
        n = q;
        n.s1 = d_i;
        n.s2 = q.s1;
        n.s3 = q.s2;
        if (q.s2 == q.s3) begin
            n.q = q.s3;
        end
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            q <= '0;
        end else begin
            q <= n;
        end
    end

    assign q_o = q.q;

endmodule

// ---- src/touch_seq.sv ----
// touch, temperature and spare input conversion sequencer
// Functional notes
// [RQ1] self mode needs self bit and pen detect
// [RQ2] touch drives alert low, starts oscillator
// [RQ3] Y drivers, stabilise, power, convert Y
// [RQ4] still touched: X drivers, convert, store X
// [RQ5] repeat while touched until power down
// [RQ6] precharge, sense, stabilise times from fields
// [RQ7] host picks scan function after alert
// [RQ8] started scan runs drivers and waits itself
// [RQ9] single or differential diode with 82x bias
// [RQ10] auto temperature conversion each interval; code converts in host mode only
// [RQ11] out-of-range flag, cleared when read
// [RQ12] threshold event pulses alert high 2 ms
// [RQ13] host temperature only in host mode
// [RQ14] battery mode gives one fifth code
// [RQ15] default battery mode rescales code by five
// [RQ16] host should use 8 bits for battery
// [RQ17] port scan converts A, B, battery
// [RQ18] host selects port scan via function field
// [RQ19] port scan only in host mode
// [RQ20] spare inputs repeat when continuous set
// [RQ21] self bit picks host or self control
// [RQ22] alert source: pen, data or either
// [RQ23] precharge then sense before touch check
// [RQ24] release between Y and X abandons scan
// [RQ25] results unsigned at programmed resolution
`timescale 1ns/1ps
module touch_seq #(
    parameter int PULSE_CYCLES = touch_seq_pkg::PULSE_CYC,
    parameter int MS_CYCLES = touch_seq_pkg::MS_CYC
) (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_i,
    // configuration
    input wire logic [7:0] conv_ctl_i,
    input wire logic ctl_wr_i,
    input wire logic [7:0] tmr_cfg_i,
    input wire logic [2:0] stab_cfg_i,
    input wire logic [1:0] res_sel_i,
    input wire logic batt_mode_i,
    input wire logic sar_pd_i,
    input wire logic spare_cont_i,
    input wire logic temp_auto_i,
    input wire logic [7:0] temp_ivl_i,
    input wire logic [11:0] temp_min_i,
    input wire logic [11:0] temp_max_i,
    input wire logic temp_irq_en_i,
    input wire logic alert_pin_sel_i,
    input wire logic temp_pin_sel_i,
    // host read strobes
    input wire logic res_rd_i,
    input wire logic flag_rd_i,
    // panel and converter
    input wire logic touch_i,
    input wire logic conv_done_i,
    input wire logic [11:0] conv_data_i,
    // drive outputs
    output logic x_drv_o,
    output logic y_drv_o,
    output logic pchg_o,
    output logic sense_o,
    output logic sar_pwr_o,
    output logic osc_on_o,
    output logic conv_start_o,
    output logic [2:0] conv_chan_o,
    output logic bias_hi_o,
    output logic first_alert_pin_o,
    output logic second_alert_pin_o,
    // results and status
    output logic [11:0] x_res_o,
    output logic [11:0] y_res_o,
    output logic [11:0] spare_input_a_res_o,
    output logic [11:0] spare_input_b_res_o,
    output logic [11:0] batt_res_o,
    output logic [11:0] low_current_diode_reading_o,
    output logic [11:0] high_current_diode_reading_o,
    output logic temp_flag_o,
    output logic busy_o
);

    localparam int PW = $clog2(PULSE_CYCLES + 1);
    localparam int MW = $clog2(MS_CYCLES + 1);

    typedef enum logic [2:0] {ST_IDLE, ST_PRE, ST_SENSE, ST_STAB, ST_CONV, ST_WAIT} st_e;

    typedef struct packed {
        st_e st;
        touch_seq_pkg::chan_e ch;
        logic [3:0] job;
        logic [15:0] cnt;
        logic pen;
        logic dav;
        logic tick;
        logic auto_run;
        logic [MW-1:0] ms_cnt;
        logic [7:0] ivl_cnt;
        logic [PW-1:0] pls;
        logic flag;
        logic [6:0][11:0] res;
        logic x_drv;
        logic y_drv;
        logic pchg;
        logic sense;
        logic pwr;
        logic osc;
        logic start;
        logic bias;
        logic pin1;
        logic pin2;
    } state_s;

    state_s q;
    state_s n;
    logic touch_s;
    logic [11:0] val;
    logic self_mode;
    logic pen_en;
    logic [3:0] fn;
    logic [1:0] alert_sel;
    logic oor;

    function automatic logic [15:0] wait_cyc(input logic [2:0] c);
        wait_cyc = 16'(({13'h0, c} + 16'h0001) * 16'(touch_seq_pkg::WAIT_UNIT_CYC));
    endfunction

    assign self_mode = conv_ctl_i[touch_seq_pkg::CTL_SELF_BIT]; // RQ21
    assign pen_en = tmr_cfg_i[touch_seq_pkg::TM_PEN_BIT]; // RQ1
    assign fn = conv_ctl_i[touch_seq_pkg::CTL_FN_MSB:touch_seq_pkg::CTL_FN_LSB];
    assign alert_sel = conv_ctl_i[touch_seq_pkg::CTL_AL_MSB:touch_seq_pkg::CTL_AL_LSB];
    assign oor = (val < temp_min_i) || (val > temp_max_i);

    input_sync u_touch_sync (
        .ref_clk_i(ref_clk_i),
        .rst_i(rst_i),
        .d_i(touch_i),
        .q_o(touch_s)
    );

    // battery code is scaled back up unless battery mode is on
    code_scaler u_scaler (
        .raw_i(conv_data_i),
        .res_i(res_sel_i),
        .up5_i(q.ch == touch_seq_pkg::CH_BAT && !batt_mode_i), // RQ14 RQ15
        .code_o(val) // RQ25
    );

    always_comb begin
        logic done;
        logic alert_low;
        done = 1'b0;
        alert_low = 1'b0;
        n = q;
        n.start = 1'b0;
        if (q.pls != '0) begin
            n.pls = q.pls - PW'(1);
        end
        if (res_rd_i) begin
            n.dav = 1'b0;
        end
        if (flag_rd_i) begin
            n.flag = 1'b0; // RQ11
        end
        unique case (q.st)
            ST_IDLE: begin
                n.pen = pen_en && touch_s;
                if (sar_pd_i) begin
                    n.st = ST_IDLE;
                end else if (self_mode && pen_en && touch_s) begin // RQ1
                    n.job = touch_seq_pkg::FN_XY;
                    n.ch = touch_seq_pkg::CH_Y;
                    n.st = ST_STAB;
                    n.cnt = wait_cyc(stab_cfg_i); // RQ6
                    n.y_drv = 1'b1; // RQ3
                    n.sense = 1'b0;
                end else if (!self_mode && ctl_wr_i && fn != touch_seq_pkg::FN_NONE) begin
                    n.job = fn; // RQ8
                    n.auto_run = 1'b0;
                    n.sense = 1'b0;
                    n.st = ST_CONV;
                    unique case (fn)
                        touch_seq_pkg::FN_XY, touch_seq_pkg::FN_Y: begin
                            n.ch = touch_seq_pkg::CH_Y;
                            n.y_drv = 1'b1;
                            n.st = ST_STAB;
                            n.cnt = wait_cyc(stab_cfg_i);
                        end
                        touch_seq_pkg::FN_X: begin
                            n.ch = touch_seq_pkg::CH_X;
                            n.x_drv = 1'b1;
                            n.st = ST_STAB;
                            n.cnt = wait_cyc(stab_cfg_i);
                        end
                        touch_seq_pkg::FN_A, touch_seq_pkg::FN_SCAN: n.ch = touch_seq_pkg::CH_A;
                        touch_seq_pkg::FN_B: n.ch = touch_seq_pkg::CH_B;
                        touch_seq_pkg::FN_BAT: n.ch = touch_seq_pkg::CH_BAT;
                        touch_seq_pkg::FN_T1, touch_seq_pkg::FN_TD: n.ch = touch_seq_pkg::CH_T1;
                        default: begin
                            n.st = ST_IDLE;
                            n.sense = 1'b1;
                        end
                    endcase
                end else if (!self_mode && q.tick) begin // RQ10
                    n.tick = 1'b0;
                    n.auto_run = 1'b1;
                    n.job = touch_seq_pkg::FN_T1;
                    n.ch = touch_seq_pkg::CH_T1;
                    n.sense = 1'b0;
                    n.st = ST_CONV;
                end
            end
            ST_PRE: begin
                if (q.cnt != '0) begin
                    n.cnt = q.cnt - 16'h0001;
                end else begin // RQ23
                    n.pchg = 1'b0;
                    n.sense = 1'b1;
                    n.cnt = wait_cyc(tmr_cfg_i[touch_seq_pkg::TM_SENSE_MSB:
                        touch_seq_pkg::TM_SENSE_LSB]); // RQ6
                    n.st = ST_SENSE;
                end
            end
            ST_SENSE: begin
                if (q.cnt != '0) begin
                    n.cnt = q.cnt - 16'h0001;
                end else begin
                    n.sense = 1'b0;
                    n.pen = pen_en && touch_s;
                    if (touch_s) begin // RQ4 RQ5
                        n.x_drv = q.ch == touch_seq_pkg::CH_X;
                        n.y_drv = q.ch == touch_seq_pkg::CH_Y;
                        n.cnt = wait_cyc(stab_cfg_i);
                        n.st = ST_STAB;
                    end else begin
                        done = 1'b1; // RQ24
                    end
                end
            end
            ST_STAB: begin
                if (q.cnt != '0) begin
                    n.cnt = q.cnt - 16'h0001;
                end else begin
                    n.st = ST_CONV; // RQ3
                end
            end
            ST_CONV: begin
                n.start = 1'b1;
                n.pwr = 1'b1;
                n.bias = q.ch == touch_seq_pkg::CH_T2; // RQ9
                n.st = ST_WAIT;
            end
            ST_WAIT: begin
                if (conv_done_i) begin
                    n.res[q.ch] = val; // RQ4 RQ25
                    n.dav = 1'b1;
                    n.x_drv = 1'b0;
                    n.y_drv = 1'b0;
                    n.pwr = 1'b0;
                    n.bias = 1'b0;
                    n.st = ST_CONV;
                    n.cnt = wait_cyc(tmr_cfg_i[touch_seq_pkg::TM_PCHG_MSB:
                        touch_seq_pkg::TM_PCHG_LSB]); // RQ6
                    unique case (q.ch)
                        touch_seq_pkg::CH_Y: begin
                            n.ch = touch_seq_pkg::CH_X;
                            n.pchg = q.job == touch_seq_pkg::FN_XY;
                            n.st = ST_PRE;
                            done = q.job != touch_seq_pkg::FN_XY;
                        end
                        touch_seq_pkg::CH_X: begin // RQ5
                            n.ch = touch_seq_pkg::CH_Y;
                            n.pchg = q.job == touch_seq_pkg::FN_XY;
                            n.st = ST_PRE;
                            done = q.job != touch_seq_pkg::FN_XY;
                        end
                        touch_seq_pkg::CH_A: begin // RQ17
                            n.ch = touch_seq_pkg::CH_B;
                            done = q.job != touch_seq_pkg::FN_SCAN;
                        end
                        touch_seq_pkg::CH_B: begin
                            n.ch = touch_seq_pkg::CH_BAT;
                            done = q.job != touch_seq_pkg::FN_SCAN;
                        end
                        touch_seq_pkg::CH_T1: begin // RQ9
                            n.ch = touch_seq_pkg::CH_T2;
                            done = q.job != touch_seq_pkg::FN_TD;
                            if (q.auto_run && oor) begin // RQ11
                                n.flag = 1'b1;
                                if (temp_irq_en_i) begin
                                    n.pls = PW'(PULSE_CYCLES); // RQ12
                                end
                            end
                        end
                        default: done = 1'b1;
                    endcase
                end
            end
        endcase
        if (done) begin
            n.st = ST_IDLE;
            n.x_drv = 1'b0;
            n.y_drv = 1'b0;
            n.pchg = 1'b0;
            n.sense = 1'b1;
            n.auto_run = 1'b0;
            if (spare_cont_i && !self_mode && q.job >= touch_seq_pkg::FN_A &&
                q.job <= touch_seq_pkg::FN_BAT) begin // RQ20
                n.st = ST_CONV;
                n.sense = 1'b0;
                n.ch = q.job == touch_seq_pkg::FN_B ? touch_seq_pkg::CH_B :
                    (q.job == touch_seq_pkg::FN_BAT ? touch_seq_pkg::CH_BAT :
                    touch_seq_pkg::CH_A);
            end
        end
        if (sar_pd_i) begin // RQ5
            n.st = ST_IDLE;
            n.x_drv = 1'b0;
            n.y_drv = 1'b0;
            n.pchg = 1'b0;
            n.pwr = 1'b0;
            n.bias = 1'b0;
            n.start = 1'b0;
            n.sense = 1'b1;
            n.auto_run = 1'b0;
        end
        // interval timer in whole milliseconds, interval is count plus one
        if (temp_auto_i) begin // RQ10
            if (q.ms_cnt >= MW'(MS_CYCLES - 1)) begin
                n.ms_cnt = '0;
                if (q.ivl_cnt >= temp_ivl_i) begin
                    n.ivl_cnt = 8'h00;
                    n.tick = 1'b1;
                end else begin
                    n.ivl_cnt = q.ivl_cnt + 8'h01;
                end
            end else begin
                n.ms_cnt = q.ms_cnt + MW'(1);
            end
        end else begin
            n.ms_cnt = '0;
            n.ivl_cnt = 8'h00;
            n.tick = 1'b0;
        end
        if (alert_sel == touch_seq_pkg::AL_PEN) begin // RQ22
            alert_low = n.pen;
        end else if (alert_sel == touch_seq_pkg::AL_DATA) begin
            alert_low = n.dav;
        end else begin
            alert_low = n.pen || n.dav;
        end
        n.osc = (n.st != ST_IDLE) || n.pen; // RQ2
        n.pin1 = alert_pin_sel_i ? 1'b1 : !alert_low; // RQ2
        n.pin2 = alert_pin_sel_i ? !alert_low : 1'b1;
        if (n.pls != '0) begin // RQ12
            n.pin1 = temp_pin_sel_i ? n.pin1 : 1'b1;
            n.pin2 = temp_pin_sel_i ? 1'b1 : n.pin2;
        end
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            q <= '0;
            q.sense <= 1'b1;
            q.pin1 <= 1'b1;
            q.pin2 <= 1'b1;
        end else begin
            q <= n;
        end
    end

    assign x_drv_o = q.x_drv;
    assign y_drv_o = q.y_drv;
    assign pchg_o = q.pchg;
    assign sense_o = q.sense;
    assign sar_pwr_o = q.pwr;
    assign osc_on_o = q.osc;
    assign conv_start_o = q.start;
    assign conv_chan_o = q.ch;
    assign bias_hi_o = q.bias;
    assign first_alert_pin_o = q.pin1;
    assign second_alert_pin_o = q.pin2;
    assign x_res_o = q.res[touch_seq_pkg::CH_X];
    assign y_res_o = q.res[touch_seq_pkg::CH_Y];
    assign spare_input_a_res_o = q.res[touch_seq_pkg::CH_A];
    assign spare_input_b_res_o = q.res[touch_seq_pkg::CH_B];
    assign batt_res_o = q.res[touch_seq_pkg::CH_BAT];
    assign low_current_diode_reading_o = q.res[touch_seq_pkg::CH_T1];
    assign high_current_diode_reading_o = q.res[touch_seq_pkg::CH_T2];
    assign temp_flag_o = q.flag;
    assign busy_o = q.osc;

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);

    sequence self_touch;
        q.st == ST_IDLE && self_mode && pen_en && touch_s && !sar_pd_i;
    endsequence
    sequence conv_then_start;
        q.st == ST_CONV ##1 q.start && q.pwr && q.st == ST_WAIT;
    endsequence

    touch_wake_a: assert property (self_touch ##0 alert_sel == touch_seq_pkg::AL_PEN && // RQ2
        !alert_pin_sel_i && temp_pin_sel_i |=> !q.pin1 && q.osc)
        else $error("touch did not lower alert and start oscillator");
    y_first_a: assert property (self_touch |=> q.y_drv && !q.x_drv && q.st == ST_STAB) // RQ3
        else $error("touch did not start with Y drivers");
    stab_conv_a: assert property (disable iff (rst_i || sar_pd_i) // RQ3
        q.st == ST_STAB && q.cnt == 16'h0000 |=> conv_then_start)
        else $error("stabilise did not lead to powered conversion");
    x_store_a: assert property (q.st == ST_WAIT && conv_done_i && // RQ4
        q.ch == touch_seq_pkg::CH_X |=> x_res_o == $past(val))
        else $error("X result not stored");
    pd_stop_a: assert property (sar_pd_i |=> q.st == ST_IDLE && !q.pwr) // RQ5
        else $error("power down did not stop sequence");
    release_abort_a: assert property (q.st == ST_SENSE && q.cnt == 16'h0000 && // RQ24
        !touch_s && !sar_pd_i |=> q.st == ST_IDLE && !q.x_drv && !q.y_drv)
        else $error("released touch did not abandon scan");
    pre_sense_a: assert property (q.st == ST_PRE && q.cnt == 16'h0000 && // RQ23
        !sar_pd_i |=> q.st == ST_SENSE && q.sense && !q.pchg)
        else $error("precharge not followed by sense");
    bias_sel_a: assert property (q.start |-> q.bias == (q.ch == touch_seq_pkg::CH_T2)) // RQ9
        else $error("diode bias wrong for channel");
    scan_order_a: assert property (q.st == ST_WAIT && conv_done_i && !sar_pd_i && // RQ17
        q.ch == touch_seq_pkg::CH_A && q.job == touch_seq_pkg::FN_SCAN
        |=> q.ch == touch_seq_pkg::CH_B ##1 q.start)
        else $error("port scan did not move to input B");
    range_flag_a: assert property (q.st == ST_WAIT && conv_done_i && q.auto_run && // RQ11
        q.ch == touch_seq_pkg::CH_T1 && oor |=> q.flag)
        else $error("out of range flag not set");
    pulse_len_a: assert property (q.st == ST_WAIT && conv_done_i && q.auto_run && // RQ12
        q.ch == touch_seq_pkg::CH_T1 && oor && temp_irq_en_i
        |=> q.pls == PW'(PULSE_CYCLES) ##1 q.pls == PW'(PULSE_CYCLES - 1))
        else $error("temperature pulse length wrong");

endmodule

// ---- src/touch_seq_pkg.sv ----
// constants and types shared by the touch and auxiliary conversion sequencer
package touch_seq_pkg;

    // clock and timing
    localparam int CLK_HZ = 10_000_000;
    localparam int WAIT_UNIT_NS = 1000;
    localparam int WAIT_UNIT_CYC = (WAIT_UNIT_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int PULSE_MS = 2;
    localparam int PULSE_CYC = PULSE_MS * (CLK_HZ / 1000);
    localparam int MS_CYC = CLK_HZ / 1000;

    // converter control byte fields
    localparam int CTL_SELF_BIT = 7;
    localparam int CTL_FN_MSB = 5;
    localparam int CTL_FN_LSB = 2;
    localparam int CTL_AL_MSB = 1;
    localparam int CTL_AL_LSB = 0;

    // timing byte fields
    localparam int TM_PEN_BIT = 7;
    localparam int TM_PCHG_MSB = 6;
    localparam int TM_PCHG_LSB = 4;
    localparam int TM_SENSE_MSB = 2;
    localparam int TM_SENSE_LSB = 0;

    // scan function codes
    localparam logic [3:0] FN_NONE = 4'h0;
    localparam logic [3:0] FN_XY = 4'h1;
    localparam logic [3:0] FN_Y = 4'h2;
    localparam logic [3:0] FN_X = 4'h3;
    localparam logic [3:0] FN_A = 4'h4;
    localparam logic [3:0] FN_B = 4'h5;
    localparam logic [3:0] FN_BAT = 4'h6;
    localparam logic [3:0] FN_T1 = 4'h7;
    localparam logic [3:0] FN_TD = 4'h8;
    localparam logic [3:0] FN_SCAN = 4'h9;

    // alert pin source select
    localparam logic [1:0] AL_PEN = 2'h0;
    localparam logic [1:0] AL_DATA = 2'h1;

    // resolution codes
    localparam logic [1:0] RES_12 = 2'h0;
    localparam logic [1:0] RES_8 = 2'h1;
    localparam logic [1:0] RES_10 = 2'h2;

    typedef enum logic [2:0] {CH_Y, CH_X, CH_A, CH_B, CH_BAT, CH_T1, CH_T2} chan_e;

endpackage
